// ### bench/rtd_biu_model.sv
/* Bus unit and hold requester model.
   Assumes the request stays up until done. */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bus unit model
// ------------------------------
module rtd_biu_model (
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_req,
   input  wire logic       i_mem_read,
   input  wire logic       i_want,
   input  wire logic [3:0] i_delay,
   output logic            o_done,
   output logic            o_hold
);
   logic [3:0] cnt_r;
   // Variable wait per cycle; hold backs off so refresh can run
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_r  <= 4'h0;
         o_done <= 1'b0;
         o_hold <= 1'b0;
      end else begin
         o_hold <= i_want && !i_req;
         o_done <= 1'b0;
         if (!(i_req && i_mem_read) || o_done) cnt_r <= 4'h0;
         else if (cnt_r == i_delay) o_done <= 1'b1;
         else cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule // rtd_biu_model
`default_nettype wire

// ### bench/rtd_monitor.sv
/* Port checker for rtd_top.
   Assumes it is bound to every rtd_top instance. */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module rtd_monitor (
   input wire logic        I_CLK,
   input wire logic        I_RSTN,
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [7:0]  I_WB_ADR,
   input wire logic [3:0]  I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   input wire logic        O_WB_ACK,
   input wire logic        I_INT_TAKEN,
   input wire logic        I_REFRESH_DONE,
   input wire logic        O_CLK_TICK,
   input wire logic        O_PROC_CLK_OUT,
   input wire logic        O_REFRESH_REQ,
   input wire logic [19:0] O_REFRESH_ADDR,
   input wire logic        O_MEM_READ,
   input wire logic        O_HOLD_ACK
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   logic       clr_wr;
   logic [8:0] row_q;
   // Write that clears power-save; row seen one clock back
   assign clr_wr = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && I_WB_ADR == 8'hF0 && I_WB_SEL[1] && !I_WB_DAT[15];
   always_ff @(posedge I_CLK) row_q <= O_REFRESH_ADDR[9:1];
   // Four undivided ticks in a row
   sequence full_speed_s;
      O_CLK_TICK [*4];
   endsequence
   ack_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("ack late");
   read_kind_a: assert property (O_MEM_READ == O_REFRESH_REQ) else $error("not a read");
   hold_drop_a: assert property (O_REFRESH_REQ |-> !O_HOLD_ACK) else $error("hold kept");
   addr_form_a: assert property (O_REFRESH_ADDR[12:10] == 3'h0 && O_REFRESH_ADDR[0]) else $error("bad addr");
   row_step_a: assert property (O_REFRESH_REQ && I_REFRESH_DONE |=>
      !O_REFRESH_REQ && O_REFRESH_ADDR[9:1] == row_q + 9'h001) else $error("row not advanced");
   tick_toggle_a: assert property (O_CLK_TICK |=> $changed(O_PROC_CLK_OUT)) else $error("no toggle");
   req_tick_a: assert property ($rose(O_REFRESH_REQ) |-> $past(O_CLK_TICK)) else $error("req off tick");
   int_speed_a: assert property (I_INT_TAKEN |-> ##[1:4] full_speed_s) else $error("still slow");
   clear_speed_a: assert property (clr_wr |-> ##[2:4] full_speed_s) else $error("still slow");
endmodule // rtd_monitor
bind rtd_top rtd_monitor u_mon (.I_CLK, .I_RSTN, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL,
   .I_WB_DAT, .O_WB_ACK, .I_INT_TAKEN, .I_REFRESH_DONE, .O_CLK_TICK, .O_PROC_CLK_OUT, .O_REFRESH_REQ,
   .O_REFRESH_ADDR, .O_MEM_READ, .O_HOLD_ACK);
`default_nettype wire

// ### bench/test_refresh_timer_and_clock_divider.sv
/* Self-checking bench for rtd_top.
   Assumes package, monitor and model compiled first. */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Bench top
// ------------------------------
module test_refresh_timer_and_clock_divider;
   logic        I_CLK = 1'b0, I_RSTN = 1'b0, req_q = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, int_t = 1'b0, want = 1'b0;
   logic [3:0]  sel = 4'h0;
   logic [7:0]  adr = 8'h00, rnd = 8'h0B;
   logic [31:0] dat = 32'h0, rdat;
   logic [19:0] addr;
   logic        ack, tick, pclk, req, mrd, hack, done, hold;
   logic [6:0]  part = 7'h00;
   logic [8:0]  row = 9'h000;
   logic [31:0] rq[$];
   int          fails = 0, cmp_count = 0, nrise = 0, g;
   localparam logic [7:0] ENA = rtd_pkg::REFRESH_ENABLE_OFS;

   rtd_top uut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_INT_TAKEN(int_t), .I_HOLD_REQ(hold), .I_REFRESH_DONE(done), .O_CLK_TICK(tick),
      .O_PROC_CLK_OUT(pclk), .O_REFRESH_REQ(req), .O_REFRESH_ADDR(addr), .O_MEM_READ(mrd), .O_HOLD_ACK(hack));
   rtd_biu_model bus_unit (.i_clk(I_CLK), .i_rstn(I_RSTN), .i_req(req), .i_mem_read(mrd),
      .i_want(want), .i_delay(rnd[3:0]), .o_done(done), .o_hold(hold));

   always #2 I_CLK = ~I_CLK;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Classic single cycle; for reads d is the expected data
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge I_CLK);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'h3;
      if (!w) rq.push_back(d);
      k = 0;
      do begin @(posedge I_CLK); k++; end while (ack !== 1'b1 && k < 50);
      cyc <= 1'b0; stb <= 1'b0;
      if (k >= 50) begin fails++; tally_and_finish(); end
   endtask

   // Clocks between two ticks (r=0) or two refresh requests (r=1)
   task automatic gap(input bit r, input logic [31:0] e);
      int n;
      n = 0;
      do begin @(posedge I_CLK); n++; end while (!(r ? req && !req_q : tick) && n < 2000);
      n = 0;
      do begin @(posedge I_CLK); n++; end while (!(r ? req && !req_q : tick) && n < 2000);
      cmp(n, e);
      if (n >= 2000) tally_and_finish();
   endtask

   // Result watcher: read data from the queue, refresh address from our own row count
   always @(posedge I_CLK) begin
      if (ack && !we && rq.size() > 0) cmp(rdat, rq.pop_front());
      if (req && !req_q) begin
         nrise++;
         cmp({12'h000, addr}, {12'h000, part, 3'b000, row, 1'b1});
      end
      if (req && done) begin
         row <= row + 9'h001;
         rnd <= lfsr(rnd);
      end
      req_q <= req;
   end

   initial begin
      repeat (12) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      wb(0, 8'hF0, 32'h0);
      wb(0, ENA, 32'h0);
      wb(1, 8'hE2, 32'h0014);
      wb(1, 8'hF0, 32'h8003);
      gap(0, 1);
      wb(0, 8'h80, 32'h0);
      wb(1, rtd_pkg::MODE_CTRL_OFS, 32'h1);
      wb(0, 8'hE2, 32'h0);
      $display("reset and mode test done");
      part = rnd[6:0];
      wb(1, 8'hE0, {16'h0, part, 9'h1FF});
      wb(0, 8'hE0, {16'h0, part, 9'h000});
      wb(1, 8'hE2, 32'hFE14);
      wb(0, 8'hE2, 32'h0014);
      want <= 1'b1;
      wb(1, ENA, 32'h8000);
      gap(1, 20);
      wb(1, ENA, 32'h0);
      wb(0, ENA, 32'h0);
      g = nrise;
      repeat (60) @(posedge I_CLK);
      cmp(nrise, g);
      cmp({31'h0, hack}, 32'h1);
      wb(1, ENA, 32'h8000);
      $display("refresh test done");
      for (int s = 0; s < 4; s++) begin
         wb(1, 8'hF0, 32'hFFFC | s);
         wb(0, 8'hF0, 32'h8000 | s);
         gap(0, 1 << (s == 0 ? 0 : s + 1));
         gap(1, 20 << (s == 0 ? 0 : s + 1));
      end
      wb(1, 8'hF0, 32'h0001);
      gap(0, 1);
      wb(1, 8'hF0, 32'h8002);
      @(posedge I_CLK) int_t <= 1'b1;
      @(posedge I_CLK) int_t <= 1'b0;
      wb(0, 8'hF0, 32'h0002);
      gap(0, 1);
      $display("power save test done");
      tally_and_finish();
   end
endmodule // test_refresh_timer_and_clock_divider
`default_nettype wire

// ### verilog/rtd_pkg.sv
/*
 Package for the refresh timer and power-save clock divider block:
 register offsets, field positions, reset values, timing constants and carriers.
 Assumes a classic Wishbone slave with 32-bit data, registers at even byte addresses, some two bytes apart in one word.
*/
`default_nettype none

package rtd_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REFRESH_PARTITION_OFS = 8'hE0;
   localparam logic [7:0] REFRESH_DIVISOR_OFS   = 8'hE2;
   localparam logic [7:0] REFRESH_ENABLE_OFS    = 8'hE4;
   localparam logic [7:0] POWER_SAVE_CTRL_OFS   = 8'hF0;
   localparam logic [7:0] MODE_CTRL_OFS         = 8'hF4;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int PART_LSB      = 9;
   localparam int PART_W        = 7;
   localparam int CNT_W         = 9;
   localparam int ENABLE_BIT    = 15;
   localparam int ADDR_W        = 20;
   localparam int ROW_LSB       = 1;
   localparam int PART_ADDR_LSB = 13;
   localparam int SEL_W         = 2;
   localparam int DIV_W         = 4;

   // ----------------------------------------------------------------
   // Reset values and decode constants
   // ----------------------------------------------------------------
   localparam logic [PART_W-1:0] PART_RST   = 7'h00;
   localparam logic [CNT_W-1:0]  CNT_RST    = 9'h000;
   localparam logic [CNT_W-1:0]  CNT_ONE    = 9'h001;
   localparam logic [SEL_W-1:0]  SEL_RST    = 2'h0;
   localparam logic [DIV_W-1:0]  DIV_BY_1   = 4'h0;
   localparam logic [DIV_W-1:0]  DIV_BY_4   = 4'h3;
   localparam logic [DIV_W-1:0]  DIV_BY_8   = 4'h7;
   localparam logic [DIV_W-1:0]  DIV_BY_16  = 4'hF;

   // Third bus state of a register write: two clocks after the bus takes it
   localparam logic [1:0] T3_DELAY = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } rtd_wb_req_s;

   typedef struct packed {
      logic              req;
      logic [ADDR_W-1:0] addr;
   } rtd_refresh_req_s;

endpackage

`default_nettype wire

// ### verilog/rtd_top.sv
/*
 Refresh interval timer, refresh address generator and power-save clock divider.
 Assumes: one 250 MHz system clock; the bus interface unit answers a refresh
 request with a one-cycle done pulse; interrupt-taken is a one-cycle pulse on
 this clock; software reaches the registers over classic Wishbone.
 The hold request comes from a pin and is filtered through three flip-flops,
 so hold acknowledge follows it a few clocks late.
 Division is an enable tick rather than a gated clock; everything that the
 divided clock paces here counts only on that tick.
 Enable writes land two clocks after the bus takes them, standing in for the
 third bus state of the instruction that wrote them.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Load interval counter at write's third state
// - Decrement counter each divided clock tick
// - At count one, request refresh and reload
// - Disable clears counter, keeps row counter
// - Power-save divides only in enhanced mode
// - Clock output toggles at each divided tick
// - Divided tick paces refresh counting too
// - Interrupt taken clears power-save enable
// - Division on/off at write's third state, select at next tick
// - Select 00,01,10,11 divides by 1,4,8,16
// - Address: partition, zeros, row, one
// - Refresh goes to bus unit as read
// - Drop hold acknowledge while refresh pending
module rtd_top (
   input  wire logic                      I_CLK,
   input  wire logic                      I_RSTN,
   // Wishbone slave
   input  wire logic                      I_WB_CYC,
   input  wire logic                      I_WB_STB,
   input  wire logic                      I_WB_WE,
   input  wire logic [7:0]                I_WB_ADR,
   input  wire logic [3:0]                I_WB_SEL,
   input  wire logic [31:0]               I_WB_DAT,
   output logic      [31:0]               O_WB_DAT,
   output logic                           O_WB_ACK,
   // Processor side
   input  wire logic                      I_INT_TAKEN,
   input  wire logic                      I_HOLD_REQ,
   input  wire logic                      I_REFRESH_DONE,
   output logic                           O_CLK_TICK,
   output logic                           O_PROC_CLK_OUT,
   output logic                           O_REFRESH_REQ,
   output logic      [rtd_pkg::ADDR_W-1:0] O_REFRESH_ADDR,
   output logic                           O_MEM_READ,
   output logic                           O_HOLD_ACK
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                       ack;
      logic [31:0]                rdat;
      logic                       enhanced;
      logic [rtd_pkg::PART_W-1:0] partition;
      logic [rtd_pkg::CNT_W-1:0]  divisor;
      logic                       ref_en;
      logic [rtd_pkg::CNT_W-1:0]  count;
      logic [rtd_pkg::CNT_W-1:0]  row;
      logic                       ps_en;
      logic [rtd_pkg::SEL_W-1:0]  ps_sel;
      logic                       ps_active;
      logic [2:0]                 hold_sync;
      logic                       hold_flt;
      logic [rtd_pkg::DIV_W-1:0]  div_cnt;
      logic                       clk_out;
      logic                       ref_pend;
      logic                       hold_ack;
      logic [1:0]                 ref_dly;
      logic                       ref_val;
      logic [1:0]                 ps_dly;
      logic                       ps_val;
   } rtd_state_s;

   rtd_state_s st_r;
   rtd_state_s st_nxt;

   // Divisor select decode, used for the live factor
   function automatic logic [rtd_pkg::DIV_W-1:0] div_decode(input logic [rtd_pkg::SEL_W-1:0] s);
      unique case (s)
         2'h0: div_decode = rtd_pkg::DIV_BY_1;
         2'h1: div_decode = rtd_pkg::DIV_BY_4;
         2'h2: div_decode = rtd_pkg::DIV_BY_8;
         2'h3: div_decode = rtd_pkg::DIV_BY_16;
      endcase
   endfunction

   logic                bus_req;
   logic                wr;
   logic                tick;
   logic                lo_we;
   logic                hi_we;

   assign bus_req = I_WB_CYC & I_WB_STB & ~st_r.ack;
   assign wr      = bus_req & I_WB_WE;
   assign lo_we   = I_WB_SEL[0];
   assign hi_we   = I_WB_SEL[1];
   // Divided tick: every clock when divider is idle
   assign tick    = (st_r.div_cnt == rtd_pkg::DIV_BY_1);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = bus_req;

      // Read data; reserved bits read zero
      st_nxt.rdat = 32'h0000_0000;
      unique case (I_WB_ADR)
         rtd_pkg::REFRESH_PARTITION_OFS:
            st_nxt.rdat[rtd_pkg::PART_LSB +: rtd_pkg::PART_W] = st_r.partition;
         rtd_pkg::REFRESH_DIVISOR_OFS:
            st_nxt.rdat[rtd_pkg::CNT_W-1:0] = st_r.divisor;
         rtd_pkg::REFRESH_ENABLE_OFS: begin
            st_nxt.rdat[rtd_pkg::CNT_W-1:0] = st_r.count;
            st_nxt.rdat[rtd_pkg::ENABLE_BIT] = st_r.ref_en;
         end
         rtd_pkg::POWER_SAVE_CTRL_OFS: begin
            st_nxt.rdat[rtd_pkg::SEL_W-1:0] = st_r.ps_sel;
            st_nxt.rdat[rtd_pkg::ENABLE_BIT] = st_r.ps_en;
         end
         rtd_pkg::MODE_CTRL_OFS:
            st_nxt.rdat[0] = st_r.enhanced;
         default: st_nxt.rdat = 32'h0000_0000;
      endcase

      // Third-state delay pipes for enable writes
      st_nxt.ref_dly = (st_r.ref_dly != 2'h0) ? st_r.ref_dly - 2'h1 : 2'h0;
      st_nxt.ps_dly  = (st_r.ps_dly  != 2'h0) ? st_r.ps_dly  - 2'h1 : 2'h0;

      // Register writes; enhanced registers are deaf in compatible mode
      if (wr) begin
         if (I_WB_ADR == rtd_pkg::MODE_CTRL_OFS && lo_we)
            st_nxt.enhanced = I_WB_DAT[0];
         if (st_r.enhanced) begin
            unique case (I_WB_ADR)
               rtd_pkg::REFRESH_PARTITION_OFS: if (hi_we)
                  st_nxt.partition = I_WB_DAT[rtd_pkg::PART_LSB +: rtd_pkg::PART_W];
               rtd_pkg::REFRESH_DIVISOR_OFS: begin
                  if (lo_we) st_nxt.divisor[7:0] = I_WB_DAT[7:0];
                  if (hi_we) st_nxt.divisor[8]   = I_WB_DAT[8];
               end
               rtd_pkg::REFRESH_ENABLE_OFS: if (hi_we) begin
                  st_nxt.ref_val = I_WB_DAT[rtd_pkg::ENABLE_BIT];
                  st_nxt.ref_dly = rtd_pkg::T3_DELAY;
               end
               rtd_pkg::POWER_SAVE_CTRL_OFS: begin
                  if (lo_we) st_nxt.ps_sel = I_WB_DAT[rtd_pkg::SEL_W-1:0];
                  if (hi_we) begin
                     st_nxt.ps_val = I_WB_DAT[rtd_pkg::ENABLE_BIT];
                     st_nxt.ps_dly = rtd_pkg::T3_DELAY;
                  end
               end
               default: ;
            endcase
         end
      end

      // Refresh enable lands in the third state
      if (st_r.ref_dly == 2'h1) begin
         st_nxt.ref_en = st_r.ref_val;
         // Disable clears the counter at once; a stale count must not read back
         if (st_r.ref_val)
            st_nxt.count = st_r.divisor;
         else
            st_nxt.count = rtd_pkg::CNT_RST;
      end
      // Power-save enable lands in the third state
      if (st_r.ps_dly == 2'h1)
         st_nxt.ps_en = st_r.ps_val;

      // Interrupt wins over a pending or landing enable write
      if (I_INT_TAKEN) begin
         st_nxt.ps_en  = 1'b0;
         st_nxt.ps_dly = 2'h0;
      end

      // Division only acts in enhanced mode
      st_nxt.ps_active = st_nxt.ps_en & st_r.enhanced;

      // Divider: reload at each tick; a select change takes effect at the next tick
      if (st_nxt.ps_active != st_r.ps_active) begin
         st_nxt.div_cnt = rtd_pkg::DIV_BY_1;
      end else if (tick) begin
         st_nxt.div_cnt = st_r.ps_active ? div_decode(st_r.ps_sel) : rtd_pkg::DIV_BY_1;
      end else begin
         st_nxt.div_cnt = st_r.div_cnt - 4'h1;
      end
      // Clock output toggles at each tick, so it runs at half the divided tick rate
      if (tick)
         st_nxt.clk_out = ~st_r.clk_out;

      // Interval counter paced by the divided tick
      if (!st_r.ref_en || !st_r.enhanced) begin
         if (st_r.ref_dly != 2'h1)
            st_nxt.count = rtd_pkg::CNT_RST;
      end else if (tick && st_r.ref_dly != 2'h1) begin
         if (st_r.count == rtd_pkg::CNT_ONE) begin
            st_nxt.count    = st_r.divisor;
            st_nxt.ref_pend = 1'b1;
         end else begin
            st_nxt.count = st_r.count - 9'h001;
         end
      end

      // Completion drops the request and advances row; a new request still wins
      if (st_r.ref_pend && I_REFRESH_DONE) begin
         st_nxt.row = st_r.row + 9'h001;
         if (!(tick && st_r.ref_en && st_r.count == rtd_pkg::CNT_ONE))
            st_nxt.ref_pend = 1'b0;
      end
      if (!st_r.ref_en)
         st_nxt.ref_pend = 1'b0;

      // Hold request is a pin: three stages, a change counts once stages two and three agree
      st_nxt.hold_sync = {st_r.hold_sync[1:0], I_HOLD_REQ};
      if (st_r.hold_sync[2] == st_r.hold_sync[1])
         st_nxt.hold_flt = st_r.hold_sync[1];

      // Hold acknowledge is withheld while a refresh waits
      st_nxt.hold_ack = st_nxt.hold_flt & ~st_nxt.ref_pend;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         st_r <= '{ack: 1'b0, rdat: 32'h0000_0000, enhanced: 1'b0,
                   partition: rtd_pkg::PART_RST, divisor: rtd_pkg::CNT_RST,
                   ref_en: 1'b0, count: rtd_pkg::CNT_RST, row: rtd_pkg::CNT_RST,
                   ps_en: 1'b0, ps_sel: rtd_pkg::SEL_RST, ps_active: 1'b0,
                   hold_sync: 3'h0, hold_flt: 1'b0, div_cnt: rtd_pkg::DIV_BY_1,
                   clk_out: 1'b0, ref_pend: 1'b0, hold_ack: 1'b0,
                   ref_dly: 2'h0, ref_val: 1'b0, ps_dly: 2'h0, ps_val: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Address is built from registers, so it is stable while the request stands
   assign O_REFRESH_ADDR = {st_r.partition, 3'h0, st_r.row, 1'b1};
   assign O_REFRESH_REQ  = st_r.ref_pend;
   assign O_MEM_READ     = st_r.ref_pend;
   assign O_HOLD_ACK     = st_r.hold_ack;
   assign O_CLK_TICK     = tick;
   assign O_PROC_CLK_OUT = st_r.clk_out;
   assign O_WB_ACK       = st_r.ack;
   assign O_WB_DAT       = st_r.rdat;

endmodule // rtd_top

`default_nettype wire
